// ### bench/ndfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ndfs_host_model #(
    parameter QUIET = 20
) (
    // Clock
    input wire logic clock,
    // Bench control: {complete, dir, b, a}
    input wire logic [3:0] cfg,
    input wire logic fire,
    output logic done,
    // Lines to the block
    output logic damp_select_in_a,
    output logic damp_select_in_b,
    output logic cmd_pulse,
    output logic cmd_dir_neg,
    output logic positioning_complete
);
    reg [5:0] quiet_cnt;
    initial begin
        quiet_cnt = 6'h0;
        done = 1'b0;
        cmd_pulse = 1'b0;
    end
    // Levels follow the bench; one pulse after a quiet spell
    always @(posedge clock) begin
        damp_select_in_a <= cfg[0];
        damp_select_in_b <= cfg[1];
        cmd_dir_neg <= cfg[2];
        positioning_complete <= cfg[3];
        cmd_pulse <= 1'b0;
        done <= 1'b0;
        if (fire) begin
            quiet_cnt <= QUIET[5:0];
        end else if (quiet_cnt == 6'h1) begin
            cmd_pulse <= 1'b1;
            done <= 1'b1;
            quiet_cnt <= 6'h0;
        end else if (quiet_cnt != 6'h0) begin
            quiet_cnt <= quiet_cnt - 6'h1;
        end
    end
endmodule // ndfs_host_model

`default_nettype wire

// ### bench/ndfs_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module ndfs_chk #(
    parameter WINDOW_CYCLES = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Adaptive results
    input wire logic adapt_n3_load,
    input wire logic [12:0] adapt_n3_freq,
    input wire logic adapt_active,
    input wire logic [4:0] adapt_n3_width,
    input wire logic [6:0] adapt_n3_depth,
    // Host lines
    input wire logic cmd_pulse,
    input wire logic positioning_complete,
    // Settings out
    input wire logic [12:0] notch3_center_freq,
    input wire logic [4:0] notch3_width,
    input wire logic [6:0] notch3_depth,
    input wire logic [12:0] notch4_center_freq,
    input wire logic notch3_enable,
    input wire logic notch4_enable,
    input wire logic [3:0] damp_enables
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Cycles since reset release
    // ----------------------------------------
    reg [2:0] up_cnt;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end

    reg sw_seen_1;
    reg sw_seen_2;
    always @(posedge clock) begin
        sw_seen_1 <= cmd_pulse && positioning_complete;
        sw_seen_2 <= sw_seen_1;
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_switch;
        cmd_pulse && positioning_complete;
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_n3_bypass: assert property (
        1'b1 |=> notch3_enable == ($past(notch3_center_freq) != 13'h1388))
        else $error("notch3 enable wrong");
    chk_n4_bypass: assert property (
        1'b1 |=> notch4_enable == ($past(notch4_center_freq) != 13'h1388))
        else $error("notch4 enable wrong");
    chk_freq_range: assert property (
        notch3_center_freq >= 13'h0032 && notch3_center_freq <= 13'h1388
        && notch4_center_freq >= 13'h0032 && notch4_center_freq <= 13'h1388)
        else $error("notch frequency out of range");
    chk_n3_legal: assert property (notch3_width <= 5'h14 && notch3_depth <= 7'h63)
        else $error("notch3 width or depth out of range");
    chk_adapt_load: assert property (
        adapt_n3_load |=> notch3_center_freq == $past(adapt_n3_freq))
        else $error("adaptive frequency not loaded");
    chk_adapt_over: assert property (
        adapt_active [*3] |-> notch3_width == adapt_n3_width
        && notch3_depth == adapt_n3_depth)
        else $error("adaptive width or depth not applied");
    chk_damp_hold: assert property (
        up_cnt == 3'h7 && !sw_seen_1 && !sw_seen_2 |-> $stable(damp_enables))
        else $error("damping set changed without switch event");
    cov_switch: cover property (s_switch);
endmodule // ndfs_chk

`default_nettype wire

// ### bench/notch_damping_filter_select_bench.sv
`timescale 1ns/1ps
`default_nettype none

module notch_damping_filter_select_bench;
    logic clock, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fire, done;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic adapt_n3_load, adapt_n4_load, adapt_active, sel_a, sel_b, pulse, dir_neg, pdone;
    logic [12:0] adapt_n3_freq, adapt_n4_freq, n3f, n4f;
    logic [4:0] adapt_n3_width, adapt_n4_width, n3w, n4w;
    logic [6:0] adapt_n3_depth, adapt_n4_depth, n3d, n4d;
    logic n3e, n4e;
    logic [3:0] damp, cfg, lanes;
    logic [15:0] tbl [0:17];
    integer error_cnt, n_compared, i;

    ndfs_top #(.WINDOW_CYCLES(8)) dut (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(lanes),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .adapt_n3_load(adapt_n3_load), .adapt_n4_load(adapt_n4_load),
        .adapt_n3_freq(adapt_n3_freq), .adapt_n4_freq(adapt_n4_freq),
        .adapt_active(adapt_active), .adapt_n3_width(adapt_n3_width),
        .adapt_n3_depth(adapt_n3_depth), .adapt_n4_width(adapt_n4_width),
        .adapt_n4_depth(adapt_n4_depth), .damp_select_in_a(sel_a), .damp_select_in_b(sel_b),
        .cmd_pulse(pulse), .cmd_dir_neg(dir_neg), .positioning_complete(pdone),
        .notch3_center_freq(n3f), .notch3_width(n3w), .notch3_depth(n3d),
        .notch4_center_freq(n4f), .notch4_width(n4w), .notch4_depth(n4d),
        .notch3_enable(n3e), .notch4_enable(n4e), .damp_enables(damp));
    ndfs_host_model host (.clock(clock), .cfg(cfg), .fire(fire), .done(done),
        .damp_select_in_a(sel_a), .damp_select_in_b(sel_b), .cmd_pulse(pulse),
        .cmd_dir_neg(dir_neg), .positioning_complete(pdone));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        integer k;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        k = 0;
        do begin @(posedge clock); k = k + 1; end while (wb_ack_o !== 1'b1 && k < 50);
        if (wb_ack_o !== 1'b1) begin error_cnt = error_cnt + 1; test_done; end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rdc(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask
    task reboot;
        @(posedge clock);
        rstn <= 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
    task sw(input logic [3:0] c, input logic [3:0] exp);
        integer k;
        @(posedge clock);
        cfg <= c;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        k = 0;
        do begin @(posedge clock); k = k + 1; end while (done !== 1'b1 && k < 60);
        if (done !== 1'b1) begin error_cnt = error_cnt + 1; test_done; end
        repeat (3) @(posedge clock);
        chk({28'h0, damp}, {28'h0, exp});
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, fire, adapt_n3_load, adapt_n4_load} = 7'h0;
        {wb_adr_i, wb_dat_i, adapt_active, cfg} = 45'h0;
        {adapt_n3_freq, adapt_n4_freq} = {13'h1388, 13'h1388};
        {adapt_n3_width, adapt_n4_width, adapt_n3_depth, adapt_n4_depth} = 24'h0;
        error_cnt = 0;
        n_compared = 0;
        lanes = 4'hf;
        tbl = '{16'h5207, 16'h4203, 16'h4605, 16'h464A, 16'h4A01, 16'h4A42, 16'h4A84,
            16'h4AC8, 16'h4E05, 16'h4F0A, 16'h5603, 16'h5B03, 16'h7203, 16'h7601,
            16'h7642, 16'h7A01, 16'h7B02, 16'hD603};
        reboot;
        rdc(8'h00, 32'h0000_1388);
        rdc(8'h0C, 32'h0000_1388);
        rdc(8'h04, 32'h0000_0002);
        rdc(8'h14, 32'h0000_0000);
        rdc(8'h18, 32'h0000_0000);
        chk({31'h0, n3e}, 32'h0);
        bus(1'b1, 8'h00, 32'h0000_000A);
        rdc(8'h00, 32'h0000_0032);
        bus(1'b1, 8'h00, 32'h0000_1770);
        rdc(8'h00, 32'h0000_1388);
        bus(1'b1, 8'h10, 32'h0000_001E);
        rdc(8'h10, 32'h0000_0014);
        bus(1'b1, 8'h14, 32'h0000_00C8);
        rdc(8'h14, 32'h0000_0063);
        bus(1'b1, 8'h10, 32'h0000_0002);
        lanes <= 4'h3;
        bus(1'b1, 8'h10, 32'h0000_0005);
        lanes <= 4'hf;
        rdc(8'h10, 32'h0000_0002);
        bus(1'b1, 8'h0C, 32'h0000_03E8);
        rdc(8'h0C, 32'h0000_03E8);
        chk({31'h0, n4e}, 32'h1);
        bus(1'b1, 8'h18, 32'h0000_0007);
        rdc(8'h18, 32'h0000_0000);
        rdc(8'h40, 32'h0000_0000);
        @(posedge clock);
        {adapt_n3_freq, adapt_n4_freq, adapt_n3_load, adapt_n4_load} <= {13'h0123, 13'h0456, 2'h3};
        @(posedge clock);
        {adapt_n3_load, adapt_n4_load} <= 2'h0;
        {adapt_n3_width, adapt_n3_depth, adapt_n4_width, adapt_n4_depth} <= 24'h3A_8B_28;
        adapt_active <= 1'b1;
        repeat (4) @(posedge clock);
        chk({19'h0, n3f}, 32'h0000_0123);
        chk({19'h0, n4f}, 32'h0000_0456);
        chk({20'h0, n3w, n3d}, 32'h0000_03A8);
        chk({20'h0, n4w, n4d}, 32'h0000_0A28);
        adapt_active <= 1'b0;
        for (i = 0; i < 18; i = i + 1) begin
            if (i == 0 || tbl[i][15:10] != tbl[i - 1][15:10]) begin
                bus(1'b1, 8'h1C, {29'h0, tbl[i][15:13]});
                bus(1'b1, 8'h18, {29'h0, tbl[i][12:10]});
                reboot;
            end
            sw(tbl[i][9:6], tbl[i][3:0]);
        end
        bus(1'b1, 8'h1C, 32'h0000_0002);
        bus(1'b1, 8'h18, 32'h0000_0002);
        reboot;
        sw(4'h8, 4'h1);
        bus(1'b1, 8'h18, 32'h0000_0004);
        sw(4'h3, 4'h1);
        sw(4'hB, 4'h8);
        rdc(8'h20, 32'h0000_0028);
        test_done;
    end
endmodule // notch_damping_filter_select_bench

bind ndfs_top ndfs_chk #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (.clock(clock), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .adapt_n3_load(adapt_n3_load), .adapt_n3_freq(adapt_n3_freq), .adapt_active(adapt_active),
    .adapt_n3_width(adapt_n3_width), .adapt_n3_depth(adapt_n3_depth), .cmd_pulse(cmd_pulse),
    .positioning_complete(positioning_complete), .notch3_center_freq(notch3_center_freq),
    .notch3_width(notch3_width), .notch3_depth(notch3_depth),
    .notch4_center_freq(notch4_center_freq), .notch3_enable(notch3_enable),
    .notch4_enable(notch4_enable), .damp_enables(damp_enables));

`default_nettype wire

// ### hw/ndfs_damp_decode.v
`timescale 1ns/1ps
`default_nettype none

module ndfs_damp_decode (
    // Selection inputs
    input wire [2:0] sel,
    input wire select_a,
    input wire select_b,
    input wire dir_neg,
    // Mode
    input wire two_dof,
    input wire pos_mode,
    input wire full_closed,
    // Result, one bit per damping filter
    output reg [3:0] enables
);

    always @* begin
        case (sel)
            3'h0: begin
                enables = 4'b0011;
            end
            3'h1: begin
                enables = select_a ? 4'b1010 : 4'b0101;
            end
            3'h2: begin
                enables = 4'b0001 << {select_b, select_a};
            end
            3'h3: begin
                enables = dir_neg ? 4'b1010 : 4'b0101;
            end
            default: begin
                // Values 4..6 depend on mode
                if (full_closed) begin
                    enables = 4'b0011;
                end else if (pos_mode && two_dof) begin
                    if (sel == 3'h4) begin
                        enables = 4'b0011;
                    end else if (sel == 3'h5) begin
                        enables = select_a ? 4'b0010 : 4'b0001;
                    end else begin
                        enables = dir_neg ? 4'b0010 : 4'b0001;
                    end
                end else if (sel == 3'h4) begin
                    enables = 4'b0111;
                end else begin
                    enables = 4'b0011;
                end
            end
        endcase
    end

endmodule // ndfs_damp_decode

`default_nettype wire

// ### hw/ndfs_map.vh
`ifndef NDFS_MAP_VH
`define NDFS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NDFS_OFF_N3_FREQ 8'h00
`define NDFS_OFF_N3_WIDTH 8'h04
`define NDFS_OFF_N3_DEPTH 8'h08
`define NDFS_OFF_N4_FREQ 8'h0C
`define NDFS_OFF_N4_WIDTH 8'h10
`define NDFS_OFF_N4_DEPTH 8'h14
`define NDFS_OFF_DAMP_SEL 8'h18
`define NDFS_OFF_CTRL 8'h1C
`define NDFS_OFF_STATUS 8'h20

// ----------------------------------------
// Ranges and reset values
// ----------------------------------------
`define NDFS_FREQ_MIN 13'h0032
`define NDFS_FREQ_MAX 13'h1388
`define NDFS_FREQ_RST 13'h1388
`define NDFS_WIDTH_MAX 5'h14
`define NDFS_WIDTH_RST 5'h02
`define NDFS_DEPTH_MAX 7'h63
`define NDFS_DEPTH_RST 7'h00
`define NDFS_SEL_MAX 3'h6
`define NDFS_SEL_RST 3'h0

// ----------------------------------------
// Control bits
// ----------------------------------------
`define NDFS_CTRL_TWO_DOF 0
`define NDFS_CTRL_POS_MODE 1
`define NDFS_CTRL_FULL_CLOSED 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define NDFS_WINDOW_NS 125000
`define NDFS_CLK_NS 10
`define NDFS_WINDOW_CYCLES (`NDFS_WINDOW_NS / `NDFS_CLK_NS)

`endif

// ### hw/ndfs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ndfs_map.vh"

module ndfs_top #(
    parameter WINDOW_CYCLES = `NDFS_WINDOW_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Adaptive filter results
    input wire adapt_n3_load,
    input wire adapt_n4_load,
    input wire [12:0] adapt_n3_freq,
    input wire [12:0] adapt_n4_freq,
    input wire adapt_active,
    input wire [4:0] adapt_n3_width,
    input wire [6:0] adapt_n3_depth,
    input wire [4:0] adapt_n4_width,
    input wire [6:0] adapt_n4_depth,
    // Host controller inputs
    input wire damp_select_in_a,
    input wire damp_select_in_b,
    input wire cmd_pulse,
    input wire cmd_dir_neg,
    input wire positioning_complete,
    // Filter settings to the control loop
    output reg [12:0] notch3_center_freq,
    output reg [4:0] notch3_width,
    output reg [6:0] notch3_depth,
    output reg [12:0] notch4_center_freq,
    output reg [4:0] notch4_width,
    output reg [6:0] notch4_depth,
    output reg notch3_enable,
    output reg notch4_enable,
    output reg [3:0] damp_enables
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_sync_a;
    reg rst_sync_b;
    wire rst_n = rst_sync_b;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    // ----------------------------------------
    // Clamp functions
    // ----------------------------------------
    function [12:0] clamp_freq;
        input [31:0] v;
        begin
            if (v < `NDFS_FREQ_MIN) begin
                clamp_freq = `NDFS_FREQ_MIN;
            end else if (v > `NDFS_FREQ_MAX) begin
                clamp_freq = `NDFS_FREQ_MAX;
            end else begin
                clamp_freq = v[12:0];
            end
        end
    endfunction

    function [4:0] clamp_width;
        input [31:0] v;
        begin
            clamp_width = (v > `NDFS_WIDTH_MAX) ? `NDFS_WIDTH_MAX : v[4:0];
        end
    endfunction

    function [6:0] clamp_depth;
        input [31:0] v;
        begin
            clamp_depth = (v > `NDFS_DEPTH_MAX) ? `NDFS_DEPTH_MAX : v[6:0];
        end
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && (&wb_sel_i);
    wire [31:0] wdat = wb_dat_i;

    // ----------------------------------------
    // Software settings
    // ----------------------------------------
    reg [12:0] sw_n3_freq;
    reg [12:0] sw_n4_freq;
    reg [4:0] sw_n3_width;
    reg [4:0] sw_n4_width;
    reg [6:0] sw_n3_depth;
    reg [6:0] sw_n4_depth;
    reg [2:0] sel_applied;
    reg [2:0] ctrl_applied;
    reg power_up_load;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_n3_freq <= `NDFS_FREQ_RST;
            sw_n4_freq <= `NDFS_FREQ_RST;
            sw_n3_width <= `NDFS_WIDTH_RST;
            sw_n4_width <= `NDFS_WIDTH_RST;
            sw_n3_depth <= `NDFS_DEPTH_RST;
            sw_n4_depth <= `NDFS_DEPTH_RST;
        end else if (bus_wr) begin
            case (wb_adr_i)
                `NDFS_OFF_N3_FREQ: begin
                    sw_n3_freq <= clamp_freq(wdat);
                end
                `NDFS_OFF_N4_FREQ: begin
                    sw_n4_freq <= clamp_freq(wdat);
                end
                `NDFS_OFF_N3_WIDTH: begin
                    sw_n3_width <= clamp_width(wdat);
                end
                `NDFS_OFF_N4_WIDTH: begin
                    sw_n4_width <= clamp_width(wdat);
                end
                `NDFS_OFF_N3_DEPTH: begin
                    sw_n3_depth <= clamp_depth(wdat);
                end
                `NDFS_OFF_N4_DEPTH: begin
                    sw_n4_depth <= clamp_depth(wdat);
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Starred settings, kept through reset
    // ----------------------------------------
    // Parameter store: rstn leaves it alone, so
    // a write waits for the next power-up latch
    reg [2:0] sel_pending = `NDFS_SEL_RST;
    reg [2:0] ctrl = 3'h0;
    wire store_wr = rst_n && bus_wr;

    always @(posedge clock) begin
        if (store_wr) begin
            case (wb_adr_i)
                `NDFS_OFF_DAMP_SEL: begin
                    if (wdat <= `NDFS_SEL_MAX) begin
                        sel_pending <= wdat[2:0];
                    end
                end
                `NDFS_OFF_CTRL: begin
                    ctrl <= wdat[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Power-up latch of starred settings
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_up_load <= 1'b1;
            sel_applied <= `NDFS_SEL_RST;
            ctrl_applied <= 3'h0;
        end else begin
            power_up_load <= 1'b0;
            if (power_up_load) begin
                sel_applied <= sel_pending;
                ctrl_applied <= ctrl;
            end
        end
    end

    // ----------------------------------------
    // Effective notch settings
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            notch3_center_freq <= `NDFS_FREQ_RST;
            notch4_center_freq <= `NDFS_FREQ_RST;
            notch3_width <= `NDFS_WIDTH_RST;
            notch4_width <= `NDFS_WIDTH_RST;
            notch3_depth <= `NDFS_DEPTH_RST;
            notch4_depth <= `NDFS_DEPTH_RST;
            notch3_enable <= 1'b0;
            notch4_enable <= 1'b0;
        end else begin
            if (adapt_n3_load) begin
                notch3_center_freq <= clamp_freq({19'h0, adapt_n3_freq});
            end else if (bus_wr && wb_adr_i == `NDFS_OFF_N3_FREQ) begin
                notch3_center_freq <= clamp_freq(wdat);
            end
            if (adapt_n4_load) begin
                notch4_center_freq <= clamp_freq({19'h0, adapt_n4_freq});
            end else if (bus_wr && wb_adr_i == `NDFS_OFF_N4_FREQ) begin
                notch4_center_freq <= clamp_freq(wdat);
            end
            if (adapt_active) begin
                notch3_width <= clamp_width({27'h0, adapt_n3_width});
                notch3_depth <= clamp_depth({25'h0, adapt_n3_depth});
                notch4_width <= clamp_width({27'h0, adapt_n4_width});
                notch4_depth <= clamp_depth({25'h0, adapt_n4_depth});
            end else begin
                notch3_width <= sw_n3_width;
                notch3_depth <= sw_n3_depth;
                notch4_width <= sw_n4_width;
                notch4_depth <= sw_n4_depth;
            end
            notch3_enable <= (notch3_center_freq != `NDFS_FREQ_MAX);
            notch4_enable <= (notch4_center_freq != `NDFS_FREQ_MAX);
        end
    end

    // ----------------------------------------
    // Command window, pulses per 0.125 ms
    // ----------------------------------------
    reg [31:0] win_cnt;
    reg win_pulses;
    reg prev_win_zero;
    reg cur_win_zero;
    wire win_end = (win_cnt == WINDOW_CYCLES - 1);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt <= 32'h0000_0000;
            win_pulses <= 1'b0;
            prev_win_zero <= 1'b1;
        end else begin
            win_cnt <= win_end ? 32'h0000_0000 : win_cnt + 32'h0000_0001;
            if (win_end) begin
                win_pulses <= 1'b0;
                prev_win_zero <= !(win_pulses || cmd_pulse);
            end else if (cmd_pulse) begin
                win_pulses <= 1'b1;
            end
        end
    end

    always @* begin
        cur_win_zero = !win_pulses;
    end

    // First pulse after a zero window, while positioning complete
    wire switch_event = cmd_pulse && cur_win_zero && prev_win_zero
        && positioning_complete;

    // ----------------------------------------
    // Damping selection
    // ----------------------------------------
    wire [3:0] next_damp_enables;

    ndfs_damp_decode u_decode (
        .sel(sel_applied),
        .select_a(damp_select_in_a),
        .select_b(damp_select_in_b),
        .dir_neg(cmd_dir_neg),
        .two_dof(ctrl_applied[`NDFS_CTRL_TWO_DOF]),
        .pos_mode(ctrl_applied[`NDFS_CTRL_POS_MODE]),
        .full_closed(ctrl_applied[`NDFS_CTRL_FULL_CLOSED]),
        .enables(next_damp_enables)
    );

    reg first_set;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            damp_enables <= 4'b0011;
            first_set <= 1'b1;
        end else if (power_up_load) begin
            // Wait for the power-up latch
            first_set <= 1'b1;
        end else if (first_set || switch_event) begin
            damp_enables <= next_damp_enables;
            first_set <= 1'b0;
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `NDFS_OFF_N3_FREQ: wb_dat_o <= {19'h0, notch3_center_freq};
                    `NDFS_OFF_N3_WIDTH: wb_dat_o <= {27'h0, notch3_width};
                    `NDFS_OFF_N3_DEPTH: wb_dat_o <= {25'h0, notch3_depth};
                    `NDFS_OFF_N4_FREQ: wb_dat_o <= {19'h0, notch4_center_freq};
                    `NDFS_OFF_N4_WIDTH: wb_dat_o <= {27'h0, notch4_width};
                    `NDFS_OFF_N4_DEPTH: wb_dat_o <= {25'h0, notch4_depth};
                    `NDFS_OFF_DAMP_SEL: wb_dat_o <= {29'h0, sel_pending};
                    `NDFS_OFF_CTRL: wb_dat_o <= {29'h0, ctrl};
                    `NDFS_OFF_STATUS: begin
                        wb_dat_o <= {22'h0, notch4_enable, notch3_enable,
                            1'b0, sel_applied, damp_enables};
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // ndfs_top

`default_nettype wire
